//--- design/csr_pkg.sv
package csr_pkg;
   // Clock rate and documented reset stretch.
   localparam int unsigned CLK_HZ = 125000000;
   localparam int unsigned STRETCH_MS = 250;
   localparam int unsigned STRETCH_CYCLES = CLK_HZ / 1000 * STRETCH_MS;
   // Pushbutton must stay low this long before it counts as a press.
   localparam int unsigned DEBOUNCE_US = 10;
   localparam int unsigned DEBOUNCE_CYCLES = CLK_HZ / 1000000 * DEBOUNCE_US;
   // Watchdog period default; no figure is documented.
   localparam int unsigned WATCHDOG_MS = 1600;
   localparam int unsigned WATCHDOG_CYCLES = CLK_HZ / 1000 * WATCHDOG_MS;
   localparam int CNT_W = 28;
   localparam logic [CNT_W-1:0] CNT_ZERO = 28'h0000000;
   localparam logic [CNT_W-1:0] CNT_ONE = 28'h0000001;

   typedef enum logic [1:0] {
      CSR_HOLD,
      CSR_STRETCH,
      CSR_RUN
   } csr_state_t;

   typedef struct packed {
      logic ram_enable_in_n;
      logic upper_byte_select_n;
      logic lower_byte_select_n;
   } csr_ram_req_t;

   typedef struct packed {
      logic ram_enable_high_byte_n;
      logic ram_enable_low_byte_n;
   } csr_ram_out_t;
endpackage

//--- design/csr_supervisor.sv
`timescale 1ns/10ps
// Contract
// - Reset is held asserted while the power-fail indication is active.
// - After the supply recovers, reset stays asserted for a further 250 ms.
// - A debounced pushbutton press yields a reset pulse of at least 250 ms.
// - When the watchdog expires without a strobe, reset is asserted.
// - During power fail both SRAM enables are forced high so the memory cannot be written.
// - The reset pin is open-drain and an external low on it acts as a pushbutton request.
// - Reset is also asserted during the power-up reset period.
// - Outside power fail each byte enable goes low only when its byte select and the RAM enable are low.
module csr_supervisor #(
   parameter int unsigned STRETCH_CYCLES = csr_pkg::STRETCH_CYCLES,
   parameter int unsigned WATCHDOG_CYCLES = csr_pkg::WATCHDOG_CYCLES,
   parameter int unsigned DEBOUNCE_CYCLES = csr_pkg::DEBOUNCE_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_power_fail,
   input wire logic i_watchdog_strobe_n,
   input wire logic i_reset_pin_n,
   input wire csr_pkg::csr_ram_req_t i_ram_req,
   output logic o_reset_pin_out,
   output logic o_reset_pin_oe_n,
   output csr_pkg::csr_ram_out_t o_ram_out,
   output logic o_watchdog_timeout
);

   localparam logic [csr_pkg::CNT_W-1:0] STRETCH_LAST = csr_pkg::CNT_W'(STRETCH_CYCLES - 1);
   localparam logic [csr_pkg::CNT_W-1:0] WATCHDOG_LAST = csr_pkg::CNT_W'(WATCHDOG_CYCLES - 1);
   localparam logic [csr_pkg::CNT_W-1:0] DEBOUNCE_LAST = csr_pkg::CNT_W'(DEBOUNCE_CYCLES - 1);

   // Counter helpers shared by the debounce, watchdog and stretch counters; all
   // three compare against a last value rather than a length to save an adder.
   function automatic logic at_last(
      input logic [csr_pkg::CNT_W-1:0] count,
      input logic [csr_pkg::CNT_W-1:0] last
   );
      return count == last;
   endfunction

   function automatic logic [csr_pkg::CNT_W-1:0] count_up(input logic [csr_pkg::CNT_W-1:0] count);
      return count + csr_pkg::CNT_ONE;
   endfunction

   // A trigger is the first cycle of an accepted press; a held button must not
   // restart the stretch over and over.
   function automatic logic press_edge(input logic now_pressed, input logic was_pressed);
      return now_pressed && !was_pressed;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   csr_pkg::csr_state_t state_reg, state_next;
   logic [csr_pkg::CNT_W-1:0] stretch_reg, stretch_next;
   logic [csr_pkg::CNT_W-1:0] wdog_reg, wdog_next;
   logic [csr_pkg::CNT_W-1:0] deb_reg, deb_next;
   logic press_reg, press_next;
   logic timeout_reg, timeout_next;
   logic drive_reg, drive_next;
   csr_pkg::csr_ram_out_t ram_reg, ram_next;
   logic pin_out_reg, pin_out_next;
   logic oe_n_reg, oe_n_next;
   logic pin_low;

   // While we drive the pin ourselves its low level is our own echo, not a press.
   assign pin_low = !i_reset_pin_n && !drive_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Any high cycle restarts the debounce, so contact bounce never adds up to a
   // press; the count then saturates while the pin stays low.
   always_comb begin
      deb_next = csr_pkg::CNT_ZERO;
      press_next = 1'b0;
      if (pin_low) begin
         if (at_last(deb_reg, DEBOUNCE_LAST)) begin
            deb_next = deb_reg;
            press_next = !press_reg && (deb_reg != csr_pkg::CNT_ZERO || DEBOUNCE_CYCLES <= 1);
            press_next = press_next || press_reg;
         end else begin
            deb_next = count_up(deb_reg);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // The count is held at zero outside RUN, so a host still in reset is never
   // blamed for a missing strobe.
   always_comb begin
      wdog_next = count_up(wdog_reg);
      timeout_next = 1'b0;
      if (state_reg != csr_pkg::CSR_RUN || !i_watchdog_strobe_n) begin
         wdog_next = csr_pkg::CNT_ZERO;
      end else if (at_last(wdog_reg, WATCHDOG_LAST)) begin
         wdog_next = csr_pkg::CNT_ZERO;
         timeout_next = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Power fail overrides every other cause, whatever state the sequence is in,
   // so it is applied last.
   always_comb begin
      state_next = state_reg;
      stretch_next = stretch_reg;
      unique case (state_reg)
         csr_pkg::CSR_HOLD: begin
            // The stretch only starts counting once the supply is back in tolerance.
            stretch_next = csr_pkg::CNT_ZERO;
            if (!i_power_fail) begin
               state_next = csr_pkg::CSR_STRETCH;
            end
         end
         csr_pkg::CSR_STRETCH: begin
            // A press cannot restart the stretch: the pin is ignored while we drive it, so press_next stays low here.
            if (press_edge(press_next, press_reg)) begin
               stretch_next = csr_pkg::CNT_ZERO;
            end else if (at_last(stretch_reg, STRETCH_LAST)) begin
               state_next = csr_pkg::CSR_RUN;
            end else begin
               stretch_next = count_up(stretch_reg);
            end
         end
         csr_pkg::CSR_RUN: begin
            stretch_next = csr_pkg::CNT_ZERO;
            if (press_edge(press_next, press_reg) || timeout_next) begin
               state_next = csr_pkg::CSR_STRETCH;
            end
         end
         default: begin
            state_next = csr_pkg::CSR_HOLD;
         end
      endcase
      if (i_power_fail) begin
         state_next = csr_pkg::CSR_HOLD;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Both byte lanes gate the same way, so one loop builds them. Power fail wins over
   // any request, so no lane can open while the supply is out of tolerance.
   logic [1:0] byte_sel_n;
   logic [1:0] ram_vec_next;

   assign byte_sel_n = {i_ram_req.upper_byte_select_n, i_ram_req.lower_byte_select_n};

   for (genvar lane = 0; lane < 2; lane++) begin : g_lane
      assign ram_vec_next[lane] = i_power_fail | byte_sel_n[lane] | i_ram_req.ram_enable_in_n;
   end

   always_comb begin
      drive_next = (state_next != csr_pkg::CSR_RUN);
      oe_n_next = !drive_next;
      // The open-drain data bit never changes; it still leaves through a flop
      // so that every output of the block is registered.
      pin_out_next = 1'b0;
      ram_next = csr_pkg::csr_ram_out_t'(ram_vec_next);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Power-up lands in HOLD so the power-up period always ends with a full stretch.
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         state_reg <= csr_pkg::CSR_HOLD;
         stretch_reg <= csr_pkg::CNT_ZERO;
      end else begin
         state_reg <= state_next;
         stretch_reg <= stretch_next;
      end
   end

   // Debounce state clears on reset, so a pin held low through reset still needs
   // a full debounce time before it counts.
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         deb_reg <= csr_pkg::CNT_ZERO;
         press_reg <= 1'b0;
      end else begin
         deb_reg <= deb_next;
         press_reg <= press_next;
      end
   end

   // The watchdog starts from zero after reset and only counts once the
   // stretch has ended.
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         wdog_reg <= csr_pkg::CNT_ZERO;
         timeout_reg <= 1'b0;
      end else begin
         wdog_reg <= wdog_next;
         timeout_reg <= timeout_next;
      end
   end

   // Outputs reset to their safe levels: reset driven and both memory lanes
   // disabled.
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         drive_reg <= 1'b1;
         oe_n_reg <= 1'b0;
         pin_out_reg <= 1'b0;
         ram_reg <= 2'h3;
      end else begin
         drive_reg <= drive_next;
         oe_n_reg <= oe_n_next;
         pin_out_reg <= pin_out_next;
         ram_reg <= ram_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Open drain: the data bit is always low; enable low means driving.
   assign o_reset_pin_out = pin_out_reg;
   assign o_reset_pin_oe_n = oe_n_reg;
   assign o_ram_out = ram_reg;
   assign o_watchdog_timeout = timeout_reg;

endmodule

//--- tb/csr_supervisor_checker.sv
`timescale 1ns/10ps
module csr_supervisor_checker #(
   parameter int unsigned STRETCH_CYCLES = 20
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_power_fail,
   input wire logic i_watchdog_strobe_n,
   input wire logic i_reset_pin_n,
   input wire csr_pkg::csr_ram_req_t i_ram_req,
   input wire logic o_reset_pin_out,
   input wire logic o_reset_pin_oe_n,
   input wire csr_pkg::csr_ram_out_t o_ram_out,
   input wire logic o_watchdog_timeout
);
   localparam int SLO = STRETCH_CYCLES - 8;
   localparam int SHI = STRETCH_CYCLES + 4;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   sequence s_held;
      (!o_reset_pin_oe_n)[*8];
   endsequence
   a_pf_holds: assert property (i_power_fail |=> !o_reset_pin_oe_n) else $error("reset free in power fail");
   a_pf_stretch: assert property ($fell(i_power_fail) |-> s_held ##[SLO:SHI] o_reset_pin_oe_n) else $error("bad stretch");
   a_pf_ram: assert property (i_power_fail |=> o_ram_out == 2'h3) else $error("ram enabled in power fail");
   a_ram_gate: assert property (!i_power_fail |=> o_ram_out == {$past(i_ram_req[1] | i_ram_req[2]),
      $past(i_ram_req[0] | i_ram_req[2])}) else $error("ram enable wrong");
   a_press_reset: assert property ((o_reset_pin_oe_n && !i_reset_pin_n)[*3] |-> ##[1:4] !o_reset_pin_oe_n)
      else $error("press ignored");
   a_pin_open: assert property (o_reset_pin_out == 1'h0) else $error("pin data high");
   a_wdt_reset: assert property (o_watchdog_timeout |=> !o_reset_pin_oe_n) else $error("timeout without reset");
   a_wdt_hold: assert property (o_watchdog_timeout |-> $past(o_reset_pin_oe_n)) else $error("timeout in reset");
   a_kick_restart: assert property (!i_watchdog_strobe_n |=> (!o_watchdog_timeout)[*8]) else $error("early timeout");
endmodule
bind csr_supervisor csr_supervisor_checker #(.STRETCH_CYCLES(STRETCH_CYCLES)) csr_supervisor_checker_inst (.i_clk,
   .i_reset, .i_power_fail, .i_watchdog_strobe_n, .i_reset_pin_n, .i_ram_req, .o_reset_pin_out, .o_reset_pin_oe_n,
   .o_ram_out, .o_watchdog_timeout);

//--- tb/csr_host_model.sv
`timescale 1ns/10ps
module csr_host_model (
   input wire logic i_clk,
   input wire logic i_kick_en,
   input wire logic i_press,
   input wire logic i_oe_n,
   output logic o_strobe_n,
   output logic o_pin_n
);
   int cnt = 0;
   // The pull-up makes the wire high once nobody pulls it low.
   assign o_pin_n = i_oe_n & !i_press;
   always @(posedge i_clk) begin
      cnt <= #1 (cnt == 19) ? 0 : cnt + 1;
      o_strobe_n <= #1 !(i_kick_en && cnt == 19);
   end
endmodule

//--- tb/test_cpu_supervisor_reset_monitor.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module test_cpu_supervisor_reset_monitor;
   logic clk = 0, rst = 1, pf = 0, kick = 0, press = 0, oe_n, pin_out, tmo, stb_n, pin_n;
   csr_pkg::csr_ram_req_t req = 3'h7;
   csr_pkg::csr_ram_out_t ram;
   int n_fail = 0, cmp_count = 0, n;
   csr_supervisor #(.STRETCH_CYCLES(20), .WATCHDOG_CYCLES(50), .DEBOUNCE_CYCLES(3)) csr_supervisor_inst (.i_clk(clk),
      .i_reset(rst), .i_power_fail(pf), .i_watchdog_strobe_n(stb_n), .i_reset_pin_n(pin_n), .i_ram_req(req),
      .o_reset_pin_out(pin_out), .o_reset_pin_oe_n(oe_n), .o_ram_out(ram), .o_watchdog_timeout(tmo));
   csr_host_model csr_host_model_inst (.i_clk(clk), .i_kick_en(kick), .i_press(press), .i_oe_n(oe_n),
      .o_strobe_n(stb_n), .o_pin_n(pin_n));
   initial forever #4 clk = !clk;
   task cyc(input int k); repeat (k) @(posedge clk); #1; endtask
   task finish_test;
      $display("checks %0d failures %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // A bounded wait keeps a stuck reset from hanging the run.
   task wait_oe(input logic v);
      n = 0;
      while (oe_n !== v) begin
         cyc(1);
         n++;
         if (n > 99) begin n_fail++; finish_test; end
      end
   endtask
   task t_powerup;
      `CHK("oe_n", 1'h0, oe_n)
      `CHK("pin_out", 1'h0, pin_out)
      wait_oe(1);
      `CHK("stretch", 1'h1, n >= 20)
   endtask
   task t_ram;
      for (int k = 0; k < 8; k++) begin
         req = k[2:0];
         cyc(2);
         `CHK("ram", {req[1] | req[2], req[0] | req[2]}, ram)
      end
   endtask
   task t_power_fail;
      pf = 1;
      cyc(2);
      `CHK("oe_n", 1'h0, oe_n)
      `CHK("ram", 2'h3, ram)
      pf = 0;
      wait_oe(1);
      `CHK("stretch", 1'h1, n >= 20)
   endtask
   task t_press;
      press = 1;
      cyc(5);
      press = 0;
      `CHK("oe_n", 1'h0, oe_n)
      wait_oe(1);
      `CHK("press", 1'h1, n >= 15)
   endtask
   task t_wdt;
      cyc(200);
      `CHK("oe_n", 1'h1, oe_n)
      kick = 0;
      wait_oe(0);
      `CHK("tmo", 1'h1, tmo)
      `CHK("wdt", 1'h1, n > 30 && n < 60)
      kick = 1;
      wait_oe(1);
   endtask
   initial begin
      cyc(10);
      rst = 0;
      kick = 1;
      t_powerup;
      t_ram;
      t_power_fail;
      t_press;
      t_wdt;
      finish_test;
   end
endmodule
